//--- rtl/backlight_smbus_register_bank.v
/*
  byte-protocol link slave and register bank of an eight-channel backlight
  controller, with dimming level, duty measurement and enable timing.
  assumes the link pins and the external dimming input are asynchronous;
  fault flags come from protection logic on mclk_i.
*/
// Behaviour
// R01: address byte high nibble must be 0x5, the backlight controller class.
// R02: address byte bit 3 must be one to be recognised.
// R03: bit 0 is direction; accept 0x58 for write, 0x59 for read.
// R04: all registers eight bits, byte protocols only; reserved bits reset zero.
// R05: brightness at index 0 is read/write, 256 steps, resets to 0xFF.
// R06: step 0 gives minimum output, current effectively off.
// R07: steps 1 to 255 map linearly onto duty up to 100 percent.
// R08: brightness writes take effect only in host absolute mode.
// R09: brightness read returns programmed level whatever the source bit.
// R10: value 0xFF gives continuous full duty.
// R11: control bit 0 switches backlight on or off, resets to zero.
// R12: control bit 1 hands brightness to external dimming input, resets zero.
// R13: control bit 2 chooses absolute or percentage, resets zero; rest reserved.
// R14: source bit wins; else interpretation picks absolute or percentage scaling.
// R15: status bit 5 shows two channels shut down.
// R16: status bit 4 shows one channel shut down.
// R17: status bit 3 shows backlight on, not a fault.
// R18: status bit 2 shows input overcurrent.
// R19: status bit 1 shows thermal shutdown.
// R20: status bit 0 is OR of faults; status resets to 0x00.
// R21: identification at index 3 read-only: panel flag, vendor, revision.
// R22: fault bit sticky; cleared by writing low or enable toggle.
// R23: backlight on within 4 ms of enable write; off at once.
// R24: percentage mode: brightness times measured external duty.
// R25: foreign address not acknowledged; data line left released.
`include "backlight_consts.vh"
module backlight_smbus_register_bank #(
  parameter [3:0] VENDOR_CODE = 4'h3, // arbitrary value
  parameter [2:0] SILICON_REV = 3'h0, // arbitrary value
  parameter integer ON_DELAY_CYCLES = `BL_ON_TIME_US * `CLK_MHZ,
  parameter integer DIM_TICK_DIV = `DIM_TICK_DIV
) (
  input wire mclk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_o,
  input wire external_dimming_input_i,
  input wire two_channels_down_i,
  input wire one_channel_down_i,
  input wire input_overcurrent_flag_i,
  input wire thermal_trip_flag_i,
  output reg backlight_on_o,
  output reg [7:0] dimming_level_o,
  output reg pwm_o
);
  localparam [9:0] ST_IDLE = 10'h001;
  localparam [9:0] ST_ADDR = 10'h002;
  localparam [9:0] ST_ADDR_ACK = 10'h004;
  localparam [9:0] ST_CMD = 10'h008;
  localparam [9:0] ST_CMD_ACK = 10'h010;
  localparam [9:0] ST_WDATA = 10'h020;
  localparam [9:0] ST_WDATA_ACK = 10'h040;
  localparam [9:0] ST_RDATA = 10'h080;
  localparam [9:0] ST_RDATA_ACK = 10'h100;
  localparam [9:0] ST_IGNORE = 10'h200;

  wire sda_s;
  wire dim_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;

  reg [9:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  reg [7:0] reg_index;
  reg read_dir;
  reg [7:0] brightness_step;
  reg backlight_enable;
  reg source_select;
  reg dimming_interpretation_select;
  reg fault_sticky;
  reg backlight_on_indicator;
  reg [31:0] on_cnt;
  reg [15:0] tick_cnt;
  reg tick;
  reg [7:0] win_cnt;
  reg [8:0] high_cnt;
  reg [8:0] duty_meas;
  reg [7:0] pwm_cnt;
  reg wr_stb;
  reg [7:0] wr_data;

  reg [7:0] rd_mux;
  reg [7:0] next_level;
  // toggling the enable or writing the fault bit low both clear it
  wire fault_clear = wr_stb && (((reg_index == `IDX_STATUS) && !wr_data[`STATUS_FAULT_BIT]) ||
    ((reg_index == `IDX_CONTROL) && (wr_data[`CTL_ENABLE_BIT] != backlight_enable)));

  wire fault_any = two_channels_down_i | one_channel_down_i | input_overcurrent_flag_i | thermal_trip_flag_i; // R20
  wire mode_external = source_select; // R14
  wire mode_absolute = ~source_select & dimming_interpretation_select; // R14
  wire addr_match = (rx_shift == `ADDR_WRITE_BYTE) || (rx_shift == `ADDR_READ_BYTE); // R01 R02 R03

  // brightness scaled by a duty measured in 256ths
  function [7:0] scale_by_duty;
    input [7:0] level;
    input [8:0] duty;
    reg [16:0] prod;
    begin
      prod = level * duty;
      scale_by_duty = prod[15:8];
    end
  endfunction

  smbus_pin_sync u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .dim_i(external_dimming_input_i),
    .sda_o(sda_s),
    .dim_o(dim_s),
    .scl_rise_o(scl_rise),
    .scl_fall_o(scl_fall),
    .start_o(start_det),
    .stop_o(stop_det)
  );

  always @* begin
    case (reg_index)
      `IDX_BRIGHTNESS: rd_mux = brightness_step; // R09
      `IDX_CONTROL: rd_mux = {5'h00, dimming_interpretation_select, source_select, backlight_enable}; // R13
      `IDX_STATUS: rd_mux = {2'h0, two_channels_down_i, one_channel_down_i, backlight_on_indicator,
                             input_overcurrent_flag_i, thermal_trip_flag_i, fault_sticky}; // R15 R16 R17 R18 R19
      `IDX_IDENT: rd_mux = {`PANEL_DRIVER_FLAG, VENDOR_CODE, SILICON_REV}; // R21
      default: rd_mux = 8'h00;
    endcase
  end

  // link slave; the data line is only ever pulled low, never driven high
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      reg_index <= 8'h00;
      read_dir <= 1'b0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      sda_o <= 1'b0;
      if (stop_det) begin
        state <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= `BIT_COUNT_ZERO;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if ((state == ST_ADDR) || (state == ST_CMD) || (state == ST_WDATA)) begin
          rx_shift <= {rx_shift[6:0], sda_s};
          bit_cnt <= bit_cnt + `BIT_COUNT_ONE;
        end else if (state == ST_RDATA) begin
          bit_cnt <= bit_cnt + `BIT_COUNT_ONE;
        end
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bit_cnt == `BIT_COUNT_BYTE) begin
              if (addr_match) begin // R01 R02 R03
                state <= ST_ADDR_ACK;
                read_dir <= rx_shift[0];
                sda_oe_o <= 1'b1;
              end else begin
                state <= ST_IGNORE; // R25
              end
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt <= `BIT_COUNT_ZERO;
            if (read_dir) begin
              state <= ST_RDATA;
              tx_shift <= rd_mux;
              sda_oe_o <= ~rd_mux[7];
            end else begin
              state <= ST_CMD;
              sda_oe_o <= 1'b0;
            end
          end
          ST_CMD: begin
            if (bit_cnt == `BIT_COUNT_BYTE) begin
              state <= ST_CMD_ACK;
              reg_index <= rx_shift;
              sda_oe_o <= 1'b1;
            end
          end
          ST_CMD_ACK: begin
            state <= ST_WDATA;
            bit_cnt <= `BIT_COUNT_ZERO;
            sda_oe_o <= 1'b0;
          end
          ST_WDATA: begin
            if (bit_cnt == `BIT_COUNT_BYTE) begin
              state <= ST_WDATA_ACK;
              wr_stb <= 1'b1;
              wr_data <= rx_shift;
              sda_oe_o <= 1'b1;
            end
          end
          ST_WDATA_ACK: begin
            state <= ST_IGNORE; // R04
            sda_oe_o <= 1'b0;
          end
          ST_RDATA: begin
            if (bit_cnt == `BIT_COUNT_BYTE) begin
              state <= ST_RDATA_ACK;
              sda_oe_o <= 1'b0;
            end else begin
              tx_shift <= {tx_shift[6:0], 1'b0};
              sda_oe_o <= ~tx_shift[6];
            end
          end
          ST_RDATA_ACK: state <= ST_IGNORE; // R04
          ST_IDLE: state <= ST_IDLE;
          ST_IGNORE: sda_oe_o <= 1'b0; // R25
          default: begin
            state <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // register writes and the sticky fault bit
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      brightness_step <= `BRIGHTNESS_RESET; // R05
      {dimming_interpretation_select, source_select, backlight_enable} <= `CONTROL_RESET; // R11 R12 R13
      fault_sticky <= 1'b0; // R20
    end else begin
      if (wr_stb && (reg_index == `IDX_BRIGHTNESS) && mode_absolute)
        brightness_step <= wr_data; // R08
      if (wr_stb && (reg_index == `IDX_CONTROL)) begin
        backlight_enable <= wr_data[`CTL_ENABLE_BIT]; // R11
        source_select <= wr_data[`CTL_SOURCE_BIT]; // R12
        dimming_interpretation_select <= wr_data[`CTL_INTERP_BIT]; // R13
      end
      // a fault present in the clearing cycle keeps the bit set
      if (fault_any)
        fault_sticky <= 1'b1; // R22
      else if (fault_clear)
        fault_sticky <= 1'b0; // R22
    end
  end

  // enable delay: on after the full wait, off on the next edge
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt <= 32'h00000000;
      backlight_on_indicator <= 1'b0;
      backlight_on_o <= 1'b0;
    end else begin
      if (!backlight_enable) begin
        on_cnt <= 32'h00000000;
        backlight_on_indicator <= 1'b0; // R23
      end else if (!backlight_on_indicator) begin
        if (on_cnt >= ON_DELAY_CYCLES - 1)
          backlight_on_indicator <= 1'b1; // R23
        else
          on_cnt <= on_cnt + 32'h00000001;
      end
      backlight_on_o <= backlight_on_indicator & backlight_enable; // R17
    end
  end

  // dimming timebase, external duty measured over 256 ticks
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 16'h0000;
      tick <= 1'b0;
      win_cnt <= 8'h00;
      high_cnt <= 9'h000;
      duty_meas <= 9'h000;
      pwm_cnt <= 8'h00;
    end else begin
      tick <= (tick_cnt == DIM_TICK_DIV - 1);
      if (tick_cnt == DIM_TICK_DIV - 1)
        tick_cnt <= 16'h0000;
      else
        tick_cnt <= tick_cnt + 16'h0001;
      if (tick) begin
        pwm_cnt <= pwm_cnt + 8'h01;
        win_cnt <= win_cnt + 8'h01;
        if (win_cnt == 8'hFF) begin
          duty_meas <= high_cnt + {8'h00, dim_s}; // R24
          high_cnt <= 9'h000;
        end else begin
          high_cnt <= high_cnt + {8'h00, dim_s};
        end
      end
    end
  end

  always @* begin
    if (mode_external)
      next_level = scale_by_duty(`BRIGHTNESS_MAX, duty_meas); // R14
    else if (mode_absolute)
      next_level = brightness_step; // R14
    else
      next_level = scale_by_duty(brightness_step, duty_meas); // R24
  end

  // level 0 never drives, 0xFF always drives while the backlight is on
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dimming_level_o <= 8'h00;
      pwm_o <= 1'b0;
    end else begin
      dimming_level_o <= next_level;
      if (!backlight_on_indicator || !backlight_enable)
        pwm_o <= 1'b0; // R11
      else if (next_level == `BRIGHTNESS_MAX)
        pwm_o <= 1'b1; // R10
      else
        pwm_o <= (pwm_cnt < next_level); // R06 R07
    end
  end
endmodule // backlight_smbus_register_bank

//--- include/backlight_consts.vh
/*
  constants of the backlight register bank: slave address, register
  indices, field positions, reset values and timing figures.
  assumes inclusion by bare name from the rtl files.
*/
`ifndef BACKLIGHT_CONSTS_VH
`define BACKLIGHT_CONSTS_VH

`define ADDR_CLASS_NIBBLE 4'h5
`define ADDR_WRITE_BYTE 8'h58
`define ADDR_READ_BYTE 8'h59

`define IDX_BRIGHTNESS 8'h00
`define IDX_CONTROL 8'h01
`define IDX_STATUS 8'h02
`define IDX_IDENT 8'h03

`define BRIGHTNESS_RESET 8'hFF
`define BRIGHTNESS_MAX 8'hFF
`define CONTROL_RESET 3'h0
`define STATUS_RESET 8'h00

`define CTL_ENABLE_BIT 0
`define CTL_SOURCE_BIT 1
`define CTL_INTERP_BIT 2
`define STATUS_FAULT_BIT 0

`define PANEL_DRIVER_FLAG 1'h1

`define BIT_COUNT_BYTE 4'h8
`define BIT_COUNT_ZERO 4'h0
`define BIT_COUNT_ONE 4'h1

`define CLK_MHZ 100
`define BL_ON_TIME_US 4000
`define DIM_TICK_DIV 100

`endif

//--- rtl/smbus_pin_sync.v
/*
  two-flop synchronisers for the link pins and the external dimming input,
  with edge, start and stop detection on the synchronised link levels.
  assumes all inputs are asynchronous to mclk_i.
*/
module smbus_pin_sync (
  input wire mclk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire dim_i,
  output reg sda_o,
  output reg dim_o,
  output reg scl_rise_o,
  output reg scl_fall_o,
  output reg start_o,
  output reg stop_o
);
  reg scl_meta;
  reg sda_meta;
  reg dim_meta;
  reg scl_s;
  reg sda_s;
  reg scl_d;
  reg sda_d;

  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      dim_meta <= 1'b0;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      dim_o <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sda_o <= 1'b1;
      scl_rise_o <= 1'b0;
      scl_fall_o <= 1'b0;
      start_o <= 1'b0;
      stop_o <= 1'b0;
    end else begin
      scl_meta <= scl_i;
      sda_meta <= sda_i;
      dim_meta <= dim_i;
      scl_s <= scl_meta;
      sda_s <= sda_meta;
      dim_o <= dim_meta;
      scl_d <= scl_s;
      sda_d <= sda_s;
      sda_o <= sda_s;
      scl_rise_o <= scl_s & ~scl_d;
      scl_fall_o <= ~scl_s & scl_d;
      // data moving while the clock is high frames a transfer
      start_o <= scl_s & scl_d & sda_d & ~sda_s;
      stop_o <= scl_s & scl_d & ~sda_d & sda_s;
    end
  end
endmodule // smbus_pin_sync

//--- verif/backlight_bank_sva.sv
/*
  port checker for the backlight register bank.
  assumes binding onto the bank top; one clock domain, async reset.
*/
module backlight_bank_sva #(
  parameter integer ON_DELAY_CYCLES = 50,
  parameter integer DIM_TICK_DIV = 2
) (
  input wire mclk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe_o,
  input wire external_dimming_input_i,
  input wire two_channels_down_i,
  input wire one_channel_down_i,
  input wire input_overcurrent_flag_i,
  input wire thermal_trip_flag_i,
  input wire backlight_on_o,
  input wire [7:0] dimming_level_o,
  input wire pwm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLAT_MAX = 520 * DIM_TICK_DIV;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // a mid level must toggle within two pwm periods
  wire mid = backlight_on_o && dimming_level_o != 8'h00 && dimming_level_o != 8'hFF;
  reg pwm_q;
  reg [15:0] flat;
  always @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pwm_q <= 1'b0;
      flat <= 16'h0000;
    end else begin
      pwm_q <= pwm_o;
      flat <= (pwm_o != pwm_q || !mid) ? 16'h0000 : flat + 16'h0001;
    end
  end
  sda_drive_zero_a: assert property (sda_o == 1'b0) else $error("data drive value not zero");
  ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6]) else $error("data pull too short");
  release_hold_a: assert property ($fell(sda_oe_o) |-> !sda_oe_o [*6]) else $error("release too short");
  full_duty_a: assert property ((dimming_level_o == 8'hFF && backlight_on_o) [*8] |-> pwm_o)
    else $error("full level not constant high");
  zero_step_a: assert property ((dimming_level_o == 8'h00) [*8] |-> !pwm_o) else $error("step zero not dark");
  dark_when_off_a: assert property ((!backlight_on_o) [*8] |-> !pwm_o) else $error("pwm while off");
  on_delay_a: assert property ($rose(backlight_on_o) |-> $past(backlight_on_o, 40) == 1'b0)
    else $error("backlight on too early");
  duty_toggle_a: assert property (flat < FLAT_MAX) else $error("mid level stuck");
  cover property ($rose(sda_oe_o));
  cover property ($rose(backlight_on_o));
  cover property (mid && pwm_o);
endmodule // backlight_bank_sva

//--- verif/smbus_host_model.sv
/*
  behavioural link host: start, stop, bit and byte transfers, byte protocols.
  assumes a pulled-up data wire resolved outside; scl period 8 mclk.
*/
module smbus_host_model (
  input wire mclk_i,
  input wire sda_i,
  output reg scl_o,
  output reg sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task half;
    repeat (4) @(negedge mclk_i);
  endtask
  // extra half before scl rises: device may still hold ack low
  task start;
    begin
      sda_oe_o = 1'b0;
      half;
      half;
      scl_o = 1'b1;
      half;
      sda_oe_o = 1'b1;
      half;
      scl_o = 1'b0;
    end
  endtask
  task stop;
    begin
      sda_oe_o = 1'b1;
      half;
      scl_o = 1'b1;
      half;
      sda_oe_o = 1'b0;
      half;
    end
  endtask
  task bit_io(input b, output r);
    begin
      sda_oe_o = !b;
      half;
      scl_o = 1'b1;
      half;
      r = sda_i;
      scl_o = 1'b0;
    end
  endtask
  task byte_io(input [7:0] tx, output [7:0] rx, output nack);
    integer k;
    reg b;
    begin
      for (k = 7; k >= 0; k--) begin
        bit_io(tx[k], b);
        rx[k] = b;
      end
      bit_io(1'b1, nack);
    end
  endtask
  task write_byte(input [7:0] addr, input [7:0] idx, input [7:0] data, output nack);
    reg [7:0] rx;
    reg n0, n1, n2;
    begin
      start;
      byte_io(addr, rx, n0);
      byte_io(idx, rx, n1);
      byte_io(data, rx, n2);
      stop;
      nack = n0 | n1 | n2;
    end
  endtask
  task read_byte(input [7:0] idx, output [7:0] data, output nack);
    reg [7:0] rx;
    reg n0, n1, n2, n3;
    begin
      start;
      byte_io(8'h58, rx, n0);
      byte_io(idx, rx, n1);
      start;
      byte_io(8'h59, rx, n2);
      byte_io(8'hFF, data, n3);
      stop;
      nack = n0 | n1 | n2;
    end
  endtask
endmodule // smbus_host_model

//--- verif/backlight_smbus_register_bank_tb_top.sv
/*
  self-checking bench of the backlight register bank with a link host model.
  assumes short on-delay and dimming tick parameters for a quick run.
*/
module backlight_smbus_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer DIV = 2;
  reg mclk_i = 1'b0;
  reg rst_i = 1'b1;
  reg dim = 1'b0;
  reg [3:0] flt = 4'h0;
  wire scl, host_oe, dut_sda, dut_oe, bl_on, pwm;
  wire [7:0] lvl;
  wire sda = !(host_oe || dut_oe);
  integer errors = 0;
  integer samples_checked = 0;
  integer i;
  reg [7:0] rd, r, a;
  reg [15:0] cnt;
  reg ack;
  always #5 mclk_i = ~mclk_i;
  backlight_smbus_register_bank #(.ON_DELAY_CYCLES(50), .DIM_TICK_DIV(DIV)) dut_u (.mclk_i(mclk_i),
    .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(dut_sda), .sda_oe_o(dut_oe),
    .external_dimming_input_i(dim), .two_channels_down_i(flt[3]), .one_channel_down_i(flt[2]),
    .input_overcurrent_flag_i(flt[1]), .thermal_trip_flag_i(flt[0]), .backlight_on_o(bl_on),
    .dimming_level_o(lvl), .pwm_o(pwm));
  smbus_host_model host_u (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks=%0d errors=%0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    begin
      host_u.write_byte(8'h58, idx, d, ack);
      chk(ack, 16'h0);
    end
  endtask
  task rdchk(input [7:0] idx, input [7:0] exp);
    begin
      host_u.read_byte(idx, rd, ack);
      chk({ack, rd}, {1'b0, exp});
    end
  endtask
  task pause(input integer n);
    repeat (n) @(negedge mclk_i);
  endtask
  function [15:0] hi_exp(input [7:0] l);
    hi_exp = (l == 8'hFF) ? 256 * DIV : l * DIV;
  endfunction
  function [7:0] stat_exp(input [3:0] f);
    stat_exp = {2'b00, f[3], f[2], 1'b0, f[1], f[0], |f};
  endfunction
  initial begin
    // about 80000 clocks, several times the length of a clean run
    #800000;
    errors++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h9762d59e));
    pause(4);
    rst_i = 1'b0;
    pause(6);
    rdchk(8'h00, 8'hFF);
    rdchk(8'h01, 8'h00);
    rdchk(8'h02, 8'h00);
    rdchk(8'h03, {1'b1, 4'h3, 3'h0});
    rdchk(8'h04, 8'h00);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h48 : (i == 1) ? 8'h50 : (i == 2) ? 8'hD8 : $urandom;
      if (a[7:1] == 7'h2C) a = a ^ 8'h80;
      host_u.write_byte(a, 8'h01, 8'h07, ack);
      chk(ack, 16'h1);
    end
    rdchk(8'h01, 8'h00);
    $display("test address done");
    r = $urandom;
    wr(8'h01, 8'h04);
    wr(8'h00, r);
    rdchk(8'h00, r);
    chk(lvl, r);
    wr(8'h01, 8'h00);
    wr(8'h00, ~r);
    rdchk(8'h00, r);
    dim = 1'b1;
    wr(8'h01, 8'h02);
    pause(1200);
    chk(lvl, 16'hFF);
    rdchk(8'h00, r);
    wr(8'h01, 8'h00);
    pause(1200);
    chk(lvl, r);
    dim = 1'b0;
    pause(1200);
    chk(lvl, 16'h0);
    $display("test modes done");
    wr(8'h01, 8'h05);
    for (i = 0; i < 300 && bl_on !== 1'b1; i++) pause(1);
    chk(bl_on, 16'h1);
    rdchk(8'h02, 8'h08);
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? r : 8'hFF;
      wr(8'h00, a);
      pause(256 * DIV + 16);
      cnt = 16'h0;
      repeat (256 * DIV) begin
        @(negedge mclk_i);
        if (pwm === 1'b1) cnt++;
      end
      chk(cnt, hi_exp(a));
    end
    wr(8'h01, 8'h04);
    chk(bl_on, 16'h0);
    rdchk(8'h02, 8'h00);
    $display("test enable done");
    for (i = 0; i < 3; i++) begin
      flt = (i == 0) ? 4'hF : ($urandom | (4'h1 << i));
      pause(4);
      rdchk(8'h02, stat_exp(flt));
      flt = 4'h0;
      rdchk(8'h02, 8'h01);
      if (i == 1) begin
        wr(8'h01, 8'h05);
        rdchk(8'h02, 8'h08);
        wr(8'h01, 8'h04);
      end else begin
        wr(8'h02, 8'h00);
      end
      rdchk(8'h02, 8'h00);
    end
    $display("test status done");
    host_u.write_byte(8'h58, 8'h03, 8'h00, ack);
    rdchk(8'h03, {1'b1, 4'h3, 3'h0});
    host_u.write_byte(8'h58, 8'h04, 8'h5A, ack);
    rdchk(8'h04, 8'h00);
    $display("test read only done");
    finish_test;
  end
endmodule // backlight_smbus_register_bank_tb_top
bind backlight_smbus_register_bank backlight_bank_sva #(.ON_DELAY_CYCLES(ON_DELAY_CYCLES),
  .DIM_TICK_DIV(DIM_TICK_DIV)) sva_u (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .external_dimming_input_i(external_dimming_input_i),
  .two_channels_down_i(two_channels_down_i), .one_channel_down_i(one_channel_down_i),
  .input_overcurrent_flag_i(input_overcurrent_flag_i), .thermal_trip_flag_i(thermal_trip_flag_i),
  .backlight_on_o(backlight_on_o), .dimming_level_o(dimming_level_o), .pwm_o(pwm_o));
